// ---- verilog/irq_enable_priority_slice.sv ----
// top: apb register slice of enable and priority control, request gating
//
// Decided for this implementation: the APB slave port and the register offsets.
`default_nettype none
`timescale 1ns/10ps
module irq_enable_priority_slice
    import irq_slice_pkg::*;
(
    input wire logic pclk,                    // system clock, 250 MHz
    input wire logic presetn,                 // async reset, active low
    input wire logic psel,                    // apb select
    input wire logic penable,                 // apb access phase
    input wire logic pwrite,                  // apb direction, 1 = write
    input wire logic [ADDR_W-1:0] paddr,      // apb byte address
    input wire logic [DATA_W-1:0] pwdata,     // apb write data
    input wire logic [3:0] pstrb,             // apb byte strobes
    output logic [DATA_W-1:0] prdata,         // apb read data
    output logic pready,                      // apb ready
    output logic pslverr,                     // apb error, unmapped address
    input wire logic timer_gate_req,          // timer external gate event
    input wire logic serial2_collision_req,   // serial port bus collision
    input wire logic serial2_event_req,       // serial port event
    input wire logic uart_rx_req,             // uart receiver event
    input wire logic timer_req,               // timer period event
    output core_req_t timer_gate_irq,         // to core, registered
    output core_req_t serial2_collision_irq,  // to core, registered
    output core_req_t serial2_event_irq,      // to core, registered
    output core_req_t uart_rx_irq,            // to core, registered
    output core_req_t timer_irq               // to core, registered
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    bus_req_t req;                            // bundled apb request
    logic access;                             // access-phase cycle
    logic wr_en;                              // write takes effect now
    logic rd_en;                              // read image latched in setup
    logic hit_en2;                            // address is enable word two
    logic hit_en3;                            // address is enable word three
    logic hit_prio;                           // address is priority word
    logic hit_flags;                          // address is flag word
    logic mapped;                             // any register hit

    logic timer_gate_irq_enable_q;            // enable word two bit 5
    logic timer_gate_irq_enable_d;
    logic serial2_collision_irq_enable_q;     // enable word three bit 2
    logic serial2_collision_irq_enable_d;
    logic serial2_event_irq_enable_q;         // enable word three bit 1
    logic serial2_event_irq_enable_d;
    logic [PRIO_W-1:0] uart_rx_irq_priority_q;  // priority bits 14-12
    logic [PRIO_W-1:0] uart_rx_irq_priority_d;
    logic [PRIO_W-1:0] timer_irq_priority_q;    // priority bits 2-0
    logic [PRIO_W-1:0] timer_irq_priority_d;

    logic [REG_W-1:0] enable_two_view;        // read image, enable two
    logic [REG_W-1:0] enable_three_view;      // read image, enable three
    logic [REG_W-1:0] priority_view;          // read image, priority two
    logic [REG_W-1:0] flags_view;             // read image, flags

    logic [DATA_W-1:0] prdata_q;              // registered read data
    logic [DATA_W-1:0] prdata_d;

    logic [NUM_SRC-1:0] src_req;              // raw requests by index
    logic [NUM_SRC-1:0] clr_mask;             // flag clear strobes
    logic [NUM_SRC-1:0] flags;                // sticky flags
    logic [NUM_SRC-1:0] src_enable;           // enable per source
    logic [PRIO_W-1:0] src_prio [NUM_SRC];    // priority per source
    core_req_t gated [NUM_SRC];               // gated requests
    core_req_t out_q [NUM_SRC];               // registered core requests
    core_req_t out_d [NUM_SRC];
    logic lo_we;                              // byte lane 0 strobed
    logic hi_we;                              // byte lane 1 strobed

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // zero-wait slave: every access completes in its first access cycle
    always_comb begin
        req.addr = paddr;
        req.write = pwrite;
        req.wdata = pwdata;
        access = psel && penable;
        wr_en = access && req.write;
        // latch in setup so the data stands when pready is sampled
        rd_en = psel && !penable && !req.write;
        lo_we = pstrb[0];
        hi_we = pstrb[1];
    end

    // address decoding
    always_comb begin
        hit_en2 = 1'b0;
        hit_en3 = 1'b0;
        hit_prio = 1'b0;
        hit_flags = 1'b0;
        if (req.addr == OFS_ENABLE_TWO) begin
            hit_en2 = 1'b1;
        end else if (req.addr == OFS_ENABLE_THREE) begin
            hit_en3 = 1'b1;
        end else if (req.addr == OFS_PRIORITY_TWO) begin
            hit_prio = 1'b1;
        end else if (req.addr == OFS_FLAGS) begin
            hit_flags = 1'b1;
        end
        mapped = hit_en2 || hit_en3 || hit_prio || hit_flags;
    end

    // handshake outputs
    always_comb begin
        pready = 1'b1;
        pslverr = access && !mapped;
        prdata = prdata_q;
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    // next values; unimplemented bits have no storage at all
    always_comb begin
        timer_gate_irq_enable_d = timer_gate_irq_enable_q;
        serial2_collision_irq_enable_d = serial2_collision_irq_enable_q;
        serial2_event_irq_enable_d = serial2_event_irq_enable_q;
        uart_rx_irq_priority_d = uart_rx_irq_priority_q;
        timer_irq_priority_d = timer_irq_priority_q;
        if (wr_en && hit_en2 && lo_we) begin
            // only bit 5 is kept, other written bits are dropped
            timer_gate_irq_enable_d =
                req.wdata[TIMER_GATE_EN_BIT];
        end
        if (wr_en && hit_en3 && lo_we) begin
            serial2_collision_irq_enable_d =
                req.wdata[COLLISION_EN_BIT];
            serial2_event_irq_enable_d =
                req.wdata[EVENT_EN_BIT];
        end
        if (wr_en && hit_prio && hi_we) begin
            uart_rx_irq_priority_d =
                req.wdata[UART_RX_PRIO_LSB +: PRIO_W];
        end
        if (wr_en && hit_prio && lo_we) begin
            timer_irq_priority_d =
                req.wdata[TIMER_PRIO_LSB +: PRIO_W];
        end
    end

    // control storage, power-on values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_gate_irq_enable_q <= EN_RESET;
            serial2_collision_irq_enable_q <= EN_RESET;
            serial2_event_irq_enable_q <= EN_RESET;
            uart_rx_irq_priority_q <= PRIO_RESET;
            timer_irq_priority_q <= PRIO_RESET;
        end else begin
            timer_gate_irq_enable_q <= timer_gate_irq_enable_d;
            serial2_collision_irq_enable_q <=
                serial2_collision_irq_enable_d;
            serial2_event_irq_enable_q <= serial2_event_irq_enable_d;
            uart_rx_irq_priority_q <= uart_rx_irq_priority_d;
            timer_irq_priority_q <= timer_irq_priority_d;
        end
    end

    // ------------------------------------------------------------------
    // read images
    // ------------------------------------------------------------------
    // all bits outside the fields read as zero
    always_comb begin
        enable_two_view = '0;
        enable_two_view[TIMER_GATE_EN_BIT] = timer_gate_irq_enable_q;
        enable_three_view = '0;
        enable_three_view[COLLISION_EN_BIT] =
            serial2_collision_irq_enable_q;
        enable_three_view[EVENT_EN_BIT] = serial2_event_irq_enable_q;
        priority_view = '0;
        priority_view[UART_RX_PRIO_LSB +: PRIO_W] =
            uart_rx_irq_priority_q;
        priority_view[TIMER_PRIO_LSB +: PRIO_W] = timer_irq_priority_q;
        flags_view = '0;
        flags_view[NUM_SRC-1:0] = flags;
    end

    // read data mux, held between reads
    always_comb begin
        prdata_d = prdata_q;
        if (rd_en) begin
            if (hit_en2) begin
                prdata_d = {16'h0000, enable_two_view};
            end else if (hit_en3) begin
                prdata_d = {16'h0000, enable_three_view};
            end else if (hit_prio) begin
                prdata_d = {16'h0000, priority_view};
            end else if (hit_flags) begin
                prdata_d = {16'h0000, flags_view};
            end else begin
                prdata_d = 32'h00000000;
            end
        end
    end

    // read data register; loaded in setup, stands through the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------------
    // flags
    // ------------------------------------------------------------------
    // flags record events whether enabled or not
    always_comb begin
        src_req[SRC_TIMER_GATE] = timer_gate_req;
        src_req[SRC_COLLISION] = serial2_collision_req;
        src_req[SRC_EVENT] = serial2_event_req;
        src_req[SRC_UART_RX] = uart_rx_req;
        src_req[SRC_TIMER] = timer_req;
        clr_mask = '0;
        if (wr_en && hit_flags && lo_we) begin
            clr_mask = req.wdata[NUM_SRC-1:0];
        end
    end

    // sticky flag bank
    irq_flag_bank u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .src_req(src_req),
        .clr_mask(clr_mask),
        .flags_q(flags)
    );

    // ------------------------------------------------------------------
    // gating and priority
    // ------------------------------------------------------------------
    // sources without an enable here are gated by priority only
    always_comb begin
        src_enable[SRC_TIMER_GATE] = timer_gate_irq_enable_q;
        src_enable[SRC_COLLISION] = serial2_collision_irq_enable_q;
        src_enable[SRC_EVENT] = serial2_event_irq_enable_q;
        src_enable[SRC_UART_RX] = 1'b1;
        src_enable[SRC_TIMER] = 1'b1;
        src_prio[SRC_TIMER_GATE] = PRIO_FIXED;
        src_prio[SRC_COLLISION] = PRIO_FIXED;
        src_prio[SRC_EVENT] = PRIO_FIXED;
        src_prio[SRC_UART_RX] = uart_rx_irq_priority_q;
        src_prio[SRC_TIMER] = timer_irq_priority_q;
    end

    // one gate per source, outputs registered toward the core
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_gate
            irq_prio_gate u_gate (
                .flag(flags[g]),
                .enable(src_enable[g]),
                .prio(src_prio[g]),
                .out(gated[g])
            );
            always_comb begin
                out_d[g] = gated[g];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_q[g] <= '0;
                end else begin
                    out_q[g] <= out_d[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // core-side outputs
    // ------------------------------------------------------------------
    always_comb begin
        timer_gate_irq = out_q[SRC_TIMER_GATE];
        serial2_collision_irq = out_q[SRC_COLLISION];
        serial2_event_irq = out_q[SRC_EVENT];
        uart_rx_irq = out_q[SRC_UART_RX];
        timer_irq = out_q[SRC_TIMER];
    end

endmodule
`default_nettype wire

// ---- verilog/irq_slice_pkg.sv ----
// package: register map, field layout and carriers of the interrupt slice
`default_nettype none
package irq_slice_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;               // decoded address width
    localparam int DATA_W = 32;               // apb data width
    localparam int REG_W = 16;                // architected register width

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ENABLE_TWO = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_THREE = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_TWO = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h00C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int TIMER_GATE_EN_BIT = 5;     // in enable word two
    localparam int COLLISION_EN_BIT = 2;      // in enable word three
    localparam int EVENT_EN_BIT = 1;          // in enable word three
    localparam int UART_RX_PRIO_LSB = 12;     // in priority word two
    localparam int TIMER_PRIO_LSB = 0;        // in priority word two
    localparam int PRIO_W = 3;                // priority field width

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic EN_RESET = 1'h0;                   // enables cleared
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;    // binary 100
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;      // source disabled
    localparam logic [PRIO_W-1:0] PRIO_FIXED = 3'h4;    // level for sources
                                                        // ranked elsewhere

    // ------------------------------------------------------------------
    // interrupt sources handled by this slice, also flag bit positions
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 5;
    localparam int SRC_TIMER_GATE = 0;
    localparam int SRC_COLLISION = 1;
    localparam int SRC_EVENT = 2;
    localparam int SRC_UART_RX = 3;
    localparam int SRC_TIMER = 4;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;              // byte address
        logic write;                          // 1 = write
        logic [DATA_W-1:0] wdata;             // write data
    } bus_req_t;

    typedef struct packed {
        logic req;                            // forwarded request
        logic [PRIO_W-1:0] level;             // its priority level
    } core_req_t;

endpackage
`default_nettype wire

// ---- verilog/irq_flag_bank.sv ----
// flag bank: sticky per-source request flags with write-one-to-clear
`default_nettype none
`timescale 1ns/10ps
module irq_flag_bank
    import irq_slice_pkg::*;
(
    input wire logic pclk,                    // system clock
    input wire logic presetn,                 // async reset, active low
    input wire logic [NUM_SRC-1:0] src_req,   // raw source requests
    input wire logic [NUM_SRC-1:0] clr_mask,  // one-cycle clear strobes
    output logic [NUM_SRC-1:0] flags_q        // sticky flags
);

    logic [NUM_SRC-1:0] flags_d;              // next flag values

    // ------------------------------------------------------------------
    // per-bit next value
    // ------------------------------------------------------------------
    // a request in the clearing cycle keeps the flag set
    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++) begin : g_flag
            always_comb begin
                if (src_req[i]) begin
                    flags_d[i] = 1'b1;
                end else if (clr_mask[i]) begin
                    flags_d[i] = 1'b0;
                end else begin
                    flags_d[i] = flags_q[i];
                end
            end
        end
    endgenerate

    // flag storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/irq_prio_gate.sv ----
// gate: forwards one flagged request when enabled and priority nonzero
`default_nettype none
`timescale 1ns/10ps
module irq_prio_gate
    import irq_slice_pkg::*;
(
    input wire logic flag,                    // sticky source flag
    input wire logic enable,                  // enable bit for the source
    input wire logic [PRIO_W-1:0] prio,       // priority field
    output core_req_t out                     // gated request and level
);

    // level 000 blocks the source whatever its enable says
    always_comb begin
        out.level = prio;
        out.req = flag && enable && (prio != PRIO_OFF);
    end

endmodule
`default_nettype wire

// ---- verification/irq_slice_asserts.sv ----
// checker: port-level properties of the enable and priority slice
`timescale 1ns/10ps
`default_nettype none
module irq_slice_asserts
    import irq_slice_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb address
    input wire logic [DATA_W-1:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb strobes
    input wire logic [DATA_W-1:0] prdata, // apb read data
    input wire logic timer_gate_req, // gate source
    input wire logic uart_rx_req, // uart source
    input wire core_req_t timer_gate_irq, // gate request out
    input wire core_req_t uart_rx_irq // uart request out
);
    // ------------------------------------------------------------
    // shadow of the gate enable and uart priority
    // ------------------------------------------------------------
    logic wr; // write access edge
    logic rd; // read access edge
    logic en_q, en_d; // gate enable shadow
    logic [PRIO_W-1:0] pu_q, pu_d; // uart priority shadow
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    // next shadow values follow accepted writes
    always_comb begin
        en_d = en_q;
        pu_d = pu_q;
        if (wr && paddr == OFS_ENABLE_TWO && pstrb[0]) begin
            en_d = pwdata[TIMER_GATE_EN_BIT];
        end
        if (wr && paddr == OFS_PRIORITY_TWO && pstrb[1]) begin
            pu_d = pwdata[UART_RX_PRIO_LSB +: PRIO_W];
        end
    end
    // shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= EN_RESET;
            pu_q <= PRIO_RESET;
        end else begin
            en_q <= en_d;
            pu_q <= pu_d;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_gate_fwd: assert property (
        (timer_gate_req && en_q) ##1 en_q |-> ##1 (timer_gate_irq.req
        && timer_gate_irq.level == PRIO_FIXED)) else $error("gate lost");
    chk_gate_block: assert property (
        !en_q && $past(!en_q) |-> !timer_gate_irq.req)
        else $error("gate request leaked");
    chk_uart_level: assert property (
        (uart_rx_req && pu_q != PRIO_OFF) ##1 pu_q != PRIO_OFF |-> ##1
        (uart_rx_irq.req && uart_rx_irq.level == $past(pu_q)))
        else $error("uart request or level wrong");
    chk_uart_off: assert property (
        pu_q == PRIO_OFF && $past(pu_q) == PRIO_OFF |-> !uart_rx_irq.req)
        else $error("disabled uart source forwarded");
    chk_read_two: assert property (
        rd && paddr == OFS_ENABLE_TWO |-> prdata[15:6] == '0
        && prdata[4:0] == '0 && prdata[5] == en_q)
        else $error("enable two read wrong");
    chk_read_three: assert property (
        rd && paddr == OFS_ENABLE_THREE |-> prdata[15:3] == '0
        && !prdata[0]) else $error("enable three spare bits set");
    chk_read_prio: assert property (
        rd && paddr == OFS_PRIORITY_TWO |-> prdata[15] == 1'b0
        && prdata[11:3] == '0 && prdata[14:12] == pu_q)
        else $error("priority read wrong");
    chk_high_zero: assert property (
        prdata[31:16] == '0) else $error("upper read half not zero");
    cover property (timer_gate_irq.req);
    cover property (uart_rx_irq.req && uart_rx_irq.level == 3'h1);
    cover property (rd && paddr == OFS_PRIORITY_TWO);
endmodule
bind irq_enable_priority_slice irq_slice_asserts irq_slice_asserts_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .timer_gate_req, .uart_rx_req, .timer_gate_irq, .uart_rx_irq
);
`default_nettype wire

// ---- verification/irq_source_model.sv ----
// source model: peripherals raising one-cycle interrupt requests
`timescale 1ns/10ps
`default_nettype none
module irq_source_model
    import irq_slice_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic [NUM_SRC-1:0] fire, // bench command per source
    output logic [NUM_SRC-1:0] src_q // request pulses to the slice
);
    logic [NUM_SRC-1:0] src_d; // next request levels
    // a request lives one cycle per command cycle
    always_comb begin
        src_d = fire;
    end
    // requests leave on a clock edge like real peripheral logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= '0;
        end else begin
            src_q <= src_d;
        end
    end
endmodule
`default_nettype wire

// ---- verification/test_irq_enable_priority_slice.sv ----
// testbench: apb register sequences and request gating of the slice
`timescale 1ns/10ps
`default_nettype none
module test_irq_enable_priority_slice;
    import irq_slice_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [NUM_SRC-1:0] fire, src;
    core_req_t g_irq, c_irq, e_irq, u_irq, t_irq;
    int mismatches, tests_run;
    localparam logic [ADDR_W-1:0] OFS_NONE = 12'h010; // unmapped word
    irq_source_model irq_source_model_inst (.pclk(pclk),
        .presetn(presetn), .fire(fire), .src_q(src));
    irq_enable_priority_slice irq_enable_priority_slice_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_gate_req(src[SRC_TIMER_GATE]),
        .serial2_collision_req(src[SRC_COLLISION]),
        .serial2_event_req(src[SRC_EVENT]),
        .uart_rx_req(src[SRC_UART_RX]), .timer_req(src[SRC_TIMER]),
        .timer_gate_irq(g_irq), .serial2_collision_irq(c_irq),
        .serial2_event_irq(e_irq), .uart_rx_irq(u_irq), .timer_irq(t_irq));
    // clock generator
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // compare one value
    task automatic check(input string what, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; read data and error taken at the access edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        er = pslverr;
        rd = prdata;
        if (n >= 50) begin
            mismatches++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        #1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask
    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] exp);
        apb(1'b0, a, '0, 4'h0);
        check(what, rd, exp);
    endtask
    // expected request word: forwarded when enabled and level nonzero
    function automatic logic [3:0] rq(input logic en, input logic [2:0] lv);
        return {en && lv != PRIO_OFF, lv};
    endfunction
    task automatic irqs(input logic [3:0] g, c, e, u, t);
        check("irqs", 32'({g_irq, c_irq, e_irq, u_irq, t_irq}),
              32'({g, c, e, u, t}));
    endtask
    // pulse sources, then wait for flag and forwarded request
    task automatic pulse(input logic [NUM_SRC-1:0] m);
        @(posedge pclk);
        fire <= m;
        @(posedge pclk);
        fire <= '0;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    // bound on the whole run
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        finish_test();
    end
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        fire = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("enable two", OFS_ENABLE_TWO, 32'h0);
        rdchk("enable three", OFS_ENABLE_THREE, 32'h0);
        rdchk("priority", OFS_PRIORITY_TWO, 32'h00004004);
        irqs(rq(0, 4), rq(0, 4), rq(0, 4), rq(0, 4), rq(0, 4));
        $display("test reset values done");
        wr(OFS_ENABLE_TWO, 32'hFFFFFFFF);
        rdchk("enable two", OFS_ENABLE_TWO, 32'h00000020);
        check("mapped error", 32'(er), 32'h0);
        wr(OFS_ENABLE_THREE, 32'hFFFFFFFF);
        rdchk("enable three", OFS_ENABLE_THREE, 32'h00000006);
        wr(OFS_PRIORITY_TWO, 32'hFFFFFFFF);
        rdchk("priority", OFS_PRIORITY_TWO, 32'h00007007);
        apb(1'b0, OFS_NONE, '0, 4'h0);
        check("unmapped error", 32'(er), 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test register access done");
        wr(OFS_ENABLE_TWO, 32'h0);
        wr(OFS_ENABLE_THREE, 32'h0);
        pulse('1);
        irqs(rq(0, 4), rq(0, 4), rq(0, 4), rq(1, 7), rq(1, 7));
        rdchk("flags", OFS_FLAGS, 32'h0000001F);
        wr(OFS_ENABLE_TWO, 32'h00000020);
        wr(OFS_ENABLE_THREE, 32'h00000004);
        irqs(rq(1, 4), rq(1, 4), rq(0, 4), rq(1, 7), rq(1, 7));
        wr(OFS_ENABLE_THREE, 32'h00000002);
        irqs(rq(1, 4), rq(0, 4), rq(1, 4), rq(1, 7), rq(1, 7));
        wr(OFS_FLAGS, 32'h0000001F);
        rdchk("flags", OFS_FLAGS, 32'h0);
        irqs(rq(0, 4), rq(0, 4), rq(0, 4), rq(0, 7), rq(0, 7));
        $display("test gating done");
        wr(OFS_PRIORITY_TWO, 32'h00001001);
        pulse('1);
        irqs(rq(1, 4), rq(0, 4), rq(1, 4), rq(1, 1), rq(1, 1));
        wr(OFS_PRIORITY_TWO, 32'h0);
        irqs(rq(1, 4), rq(0, 4), rq(1, 4), rq(1, 0), rq(1, 0));
        rdchk("flags", OFS_FLAGS, 32'h0000001F);
        $display("test priority done");
        finish_test();
    end
endmodule
`default_nettype wire
